// ---- mbw_core.sv ----
module mbw_core
   import mbw_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   rst_b,
   // configuration from the drive
   input  wire logic [7:0] own_address,
   input  wire logic [7:0] run_source_select,
   // received payload from the framing engine
   input  wire logic   rx_valid,
   input  wire logic [7:0] rx_byte,
   input  wire logic   rx_end,
   input  wire logic   rx_crc_ok,
   // reply payload to the framing engine
   output logic        tx_valid,
   output logic [7:0]  tx_data,
   output logic        tx_last,
   input  wire logic   tx_ready,
   // drive commands
   output logic        run_command,
   output logic        reverse_direction,
   output logic        outside_fault_flag,
   output logic        trip_clear_flag,
   output logic        terminal_one_function,
   output logic        terminal_two_function,
   output logic        terminal_three_function,
   output logic        terminal_four_function,
   output logic        terminal_five_function,
   output logic        terminal_six_function,
   output logic        terminal_seven_function,
   output logic [31:0] output_frequency_setting,
   output logic [15:0] coil_command_word
);
   import mbw_pkg::*;

   mbw_frame_if rx_if ();
   mbw_frame_if tx_if ();

   mbw_state_type state_q;
   mbw_byte_type  req_q [0:5];
   logic [2:0]    len_q;
   logic [15:0]   coil_word_q;
   logic [15:0]   freq_upper_q;
   logic [15:0]   freq_lower_q;
   logic          run_q;
   logic          reply_valid_q;
   logic [2:0]    reply_len_q;
   mbw_byte_type  reply_q [0:5];

   // decoded request fields
   logic [7:0]    req_addr;
   logic [7:0]    req_func;
   logic [15:0]   req_field;
   logic [15:0]   req_data;
   logic [16:0]   target;
   logic          is_bcast;
   logic [7:0]    exc_code;
   logic          do_coil;
   logic          do_reg;
   logic [15:0]   coil_set;
   logic [15:0]   coil_clr;

   // receive side collects the payload bytes
   mbw_rx_collect u_rx (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .rx_valid  (rx_valid),
      .rx_byte   (rx_byte),
      .rx_end    (rx_end),
      .rx_crc_ok (rx_crc_ok),
      .frame     (rx_if.src)
   );

   // transmit side serialises the reply
   mbw_tx_serial u_tx (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .frame    (tx_if.snk),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .tx_ready (tx_ready)
   );

   // frames are refused while a request is being handled or answered
   assign rx_if.busy = (state_q != ST_IDLE);

   // field extraction, fields arrive high byte first
   assign req_addr  = req_q[0];
   assign req_func  = req_q[1];
   assign req_field = {req_q[2], req_q[3]};
   assign req_data  = {req_q[4], req_q[5]};
   assign target    = {1'b0, req_field} + 17'h00001;
   assign is_bcast  = (req_addr == BROADCAST_ADDR);

   // command decode and validity checks
   always_comb begin
      exc_code = 8'h00;
      do_coil  = 1'b0;
      do_reg   = 1'b0;
      case (req_func)
         FN_WRITE_COIL: begin
            if (len_q != FRAME_BYTES) begin
               exc_code = EXC_ILLEGAL_DATA;
            end else if (target < COIL_FIRST || target > COIL_LAST) begin
               exc_code = EXC_ILLEGAL_ADDR;
            end else if (req_data != COIL_ON && req_data != COIL_OFF) begin
               exc_code = EXC_ILLEGAL_DATA;
            end else begin
               do_coil = 1'b1;
            end
         end
         FN_WRITE_REG: begin
            if (len_q != FRAME_BYTES) begin
               exc_code = EXC_ILLEGAL_DATA;
            end else if (target != REG_FREQ_UPPER && target != REG_FREQ_LOWER &&
                         target != REG_COIL_WORD) begin
               exc_code = EXC_ILLEGAL_ADDR;
            end else begin
               do_reg = 1'b1;
            end
         end
         FN_LOOPBACK: begin
            if (len_q != FRAME_BYTES) begin
               exc_code = EXC_ILLEGAL_DATA;
            end else if (req_field != LOOP_SUB_ECHO) begin
               exc_code = EXC_ILLEGAL_FUNC;
            end
         end
         FN_READ_REGS, FN_WRITE_REGS: begin
            // count check only; a valid count is still answered with an illegal function exception
            if (req_data == 16'h0000 || req_data > MAX_REGS) begin
               exc_code = EXC_ILLEGAL_DATA;
            end else begin
               exc_code = EXC_ILLEGAL_FUNC;
            end
         end
         default: begin
            exc_code = EXC_ILLEGAL_FUNC;
         end
      endcase
   end

   // bit masks for a single coil write
   // bit n of the word is coil n, bit 0 has no coil behind it
   always_comb begin
      coil_set = 16'h0000;
      coil_clr = 16'h0000;
      if (do_coil) begin
         if (req_data == COIL_ON) begin
            coil_set[target[3:0]] = 1'b1;
         end else begin
            coil_clr[target[3:0]] = 1'b1;
         end
      end
   end

   // request handling sequence
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (rx_if.valid && (rx_if.bytes[0] == own_address ||
                                   rx_if.bytes[0] == BROADCAST_ADDR)) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_q <= is_bcast ? ST_IDLE : ST_SEND;
            end
            ST_SEND: begin
               // leave only once the serialiser has drained, so a new request
               // can never overwrite a reply that is still going out
               if (!reply_valid_q && !tx_if.busy) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // latch the accepted request
   // frames for other slaves are latched too but never leave the idle state
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         len_q <= 3'd0;
         for (int i = 0; i < 6; i++) req_q[i] <= 8'h00;
      end else if (state_q == ST_IDLE && rx_if.valid) begin
         len_q <= rx_if.len;
         req_q <= rx_if.bytes;
      end
   end

   // packed coil word: single coils or the whole word through register REG_COIL_WORD
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         coil_word_q <= COIL_WORD_RESET;
      end else if (state_q == ST_EXEC) begin
         if (do_reg && target == REG_COIL_WORD) begin
            coil_word_q <= req_data & COIL_WORD_MASK;
         end else begin
            coil_word_q <= (coil_word_q | coil_set) & ~coil_clr;
         end
      end
   end

   // frequency setpoint words, each accepted alone
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         freq_upper_q <= FREQ_RESET;
         freq_lower_q <= FREQ_RESET;
      end else if (state_q == ST_EXEC && do_reg) begin
         if (target == REG_FREQ_UPPER) begin
            freq_upper_q <= req_data;
         end
         if (target == REG_FREQ_LOWER) begin
            freq_lower_q <= req_data;
         end
      end
   end

   // run is honoured only with the communication run source selected
   // dropping the source selection stops the drive one cycle later
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 1'b0;
      end else begin
         run_q <= coil_word_q[BIT_RUN] && (run_source_select == RUN_SRC_MODBUS);
      end
   end

   // build the reply: echo on success, short exception frame otherwise
   // broadcasts never get here, so their exceptions stay silent as well
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reply_valid_q <= 1'b0;
         reply_len_q   <= 3'd0;
         for (int i = 0; i < 6; i++) reply_q[i] <= 8'h00;
      end else if (state_q == ST_EXEC && !is_bcast) begin
         reply_valid_q <= 1'b1;
         if (exc_code == 8'h00) begin
            reply_len_q <= FRAME_BYTES;
            reply_q     <= req_q;
         end else begin
            reply_len_q <= EXC_BYTES;
            reply_q[0]  <= req_addr;
            reply_q[1]  <= req_func | EXC_FLAG;
            reply_q[2]  <= exc_code;
            reply_q[3]  <= 8'h00;
            reply_q[4]  <= 8'h00;
            reply_q[5]  <= 8'h00;
         end
      end else begin
         reply_valid_q <= 1'b0;
      end
   end

   assign tx_if.valid = reply_valid_q;
   assign tx_if.len   = reply_len_q;
   assign tx_if.bytes = reply_q;

   // drive command outputs straight from the stored word, except run_command which comes from the gated run_q
   assign run_command             = run_q;
   assign reverse_direction       = coil_word_q[BIT_DIR];
   assign outside_fault_flag      = coil_word_q[BIT_EXT];
   assign trip_clear_flag         = coil_word_q[BIT_TRIP];
   assign terminal_one_function   = coil_word_q[BIT_TERM_LO];
   assign terminal_two_function   = coil_word_q[BIT_TERM_LO + 1];
   assign terminal_three_function = coil_word_q[BIT_TERM_LO + 2];
   assign terminal_four_function  = coil_word_q[BIT_TERM_LO + 3];
   assign terminal_five_function  = coil_word_q[BIT_TERM_LO + 4];
   assign terminal_six_function   = coil_word_q[BIT_TERM_LO + 5];
   assign terminal_seven_function = coil_word_q[BIT_TERM_HI];
   // unsigned count of 0.01 Hz steps, upper word first
   assign output_frequency_setting = {freq_upper_q, freq_lower_q};
   assign coil_command_word        = coil_word_q;
endmodule : mbw_core

// ---- mbw_pkg.sv ----
package mbw_pkg;
   // function codes handled or recognised by the command handler, plus the broadcast address and the communication run source code
   localparam logic [7:0] FN_READ_REGS   = 8'h03;
   localparam logic [7:0] FN_WRITE_COIL  = 8'h05;
   localparam logic [7:0] FN_WRITE_REG   = 8'h06;
   localparam logic [7:0] FN_LOOPBACK    = 8'h08;
   localparam logic [7:0] FN_WRITE_REGS  = 8'h10;
   localparam logic [7:0] BROADCAST_ADDR = 8'h00;
   localparam logic [7:0] RUN_SRC_MODBUS = 8'h03;
   // exception answer encodings
   localparam logic [7:0] EXC_FLAG          = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_DATA  = 8'h03;
   // coil change data and loop-back subcode
   localparam logic [15:0] COIL_ON       = 16'hff00;
   localparam logic [15:0] COIL_OFF      = 16'h0000;
   localparam logic [15:0] LOOP_SUB_ECHO = 16'h0000;
   // target numbers after the plus-one correction, and the register count limit
   localparam logic [16:0] COIL_FIRST     = 17'h00001;
   localparam logic [16:0] COIL_LAST      = 17'h0000f;
   localparam logic [16:0] REG_FREQ_UPPER = 17'h00001;
   localparam logic [16:0] REG_FREQ_LOWER = 17'h00002;
   localparam logic [16:0] REG_COIL_WORD  = 17'h01f01;
   localparam logic [15:0] MAX_REGS       = 16'h0010;
   // packed coil word layout
   localparam int BIT_RUN     = 1;
   localparam int BIT_DIR     = 2;
   localparam int BIT_EXT     = 3;
   localparam int BIT_TRIP    = 4;
   localparam int BIT_TERM_LO = 7;
   localparam int BIT_TERM_HI = 13;
   localparam logic [15:0] COIL_WORD_MASK = 16'hfffe;
   // reset values and frame geometry
   localparam logic [15:0] COIL_WORD_RESET = 16'h0000;
   localparam logic [15:0] FREQ_RESET      = 16'h0000;
   localparam logic [2:0]  FRAME_BYTES     = 3'd6;
   localparam logic [2:0]  FRAME_LONG      = 3'd7;
   localparam logic [2:0]  EXC_BYTES       = 3'd3;
   typedef logic [7:0] mbw_byte_type;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} mbw_state_type;
endpackage : mbw_pkg

// ---- mbw_frame_if.sv ----
interface mbw_frame_if;
   import mbw_pkg::*;
   logic         valid;
   logic [2:0]   len;
   mbw_byte_type bytes [0:5];
   logic         busy;
   // producer offers a frame, consumer reports it cannot take one
   modport src (output valid, output len, output bytes, input busy);
   modport snk (input valid, input len, input bytes, output busy);
endinterface : mbw_frame_if

// ---- mbw_rx_collect.sv ----
module mbw_rx_collect
   import mbw_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   rst_b,
   // byte stream from the framing engine, crc already stripped
   input  wire logic   rx_valid,
   input  wire logic [7:0] rx_byte,
   input  wire logic   rx_end,
   input  wire logic   rx_crc_ok,
   // collected frame towards the command core
   mbw_frame_if.src    frame
);
   import mbw_pkg::*;
   logic [2:0]   count_q;
   mbw_byte_type buf_q [0:5];
   logic         valid_q;

   // byte counter saturates at the long-frame marker
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 3'd0;
      end else if (rx_end) begin
         count_q <= 3'd0;
      end else if (rx_valid && count_q != FRAME_LONG) begin
         count_q <= count_q + 3'd1;
      end
   end

   // keep the first six payload bytes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 6; i++) buf_q[i] <= 8'h00;
      end else if (rx_valid && count_q < FRAME_BYTES) begin
         buf_q[count_q] <= rx_byte;
      end
   end

   // offer a good frame; a frame arriving while the core is busy is dropped
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= rx_end && rx_crc_ok && !frame.busy && count_q >= 3'd2;
      end
   end

   assign frame.valid = valid_q;
   assign frame.bytes = buf_q;
   // length is held only until the next frame ends, the core latches it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame.len <= 3'd0;
      end else if (rx_end) begin
         frame.len <= count_q;
      end
   end
endmodule : mbw_rx_collect

// ---- mbw_tx_serial.sv ----
module mbw_tx_serial
   import mbw_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   rst_b,
   // reply frame from the command core
   mbw_frame_if.snk    frame,
   // byte stream to the framing engine, which appends the crc
   output logic        tx_valid,
   output logic [7:0]  tx_data,
   output logic        tx_last,
   input  wire logic   tx_ready
);
   import mbw_pkg::*;
   mbw_byte_type buf_q [0:5];
   logic [2:0]   len_q;
   logic [2:0]   idx_q;
   logic         busy_q;
   logic [7:0]   data_q;
   logic         last_q;

   // capture a reply and walk through it under tx_ready back-pressure
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         len_q  <= 3'd0;
         idx_q  <= 3'd0;
         for (int i = 0; i < 6; i++) buf_q[i] <= 8'h00;
      end else if (!busy_q) begin
         if (frame.valid) begin
            busy_q <= 1'b1;
            len_q  <= frame.len;
            idx_q  <= 3'd0;
            buf_q  <= frame.bytes;
         end
      end else if (tx_ready) begin
         if (idx_q == len_q - 3'd1) begin
            busy_q <= 1'b0;
         end
         idx_q <= idx_q + 3'd1;
      end
   end

   // offered byte and last mark are registered so the outputs come from flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= 8'h00;
         last_q <= 1'b0;
      end else if (!busy_q) begin
         if (frame.valid) begin
            data_q <= frame.bytes[0];
            last_q <= (frame.len == 3'd1);
         end
      end else if (tx_ready) begin
         last_q <= (idx_q + 3'd2 == len_q);
         if (!last_q) begin
            data_q <= buf_q[idx_q + 3'd1];
         end
      end
   end

   assign frame.busy = busy_q;
   assign tx_valid   = busy_q;
   assign tx_data    = data_q;
   assign tx_last    = last_q;
endmodule : mbw_tx_serial

// ---- mbw_core_chk.sv ----
module mbw_core_chk
   import mbw_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_b,
   // request side
   input wire logic [7:0]  own_address,
   input wire logic [7:0]  run_source_select,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_byte,
   input wire logic        rx_end,
   input wire logic        rx_crc_ok,
   // reply side
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic        tx_ready,
   // drive commands
   input wire logic        run_command,
   input wire logic        reverse_direction,
   input wire logic        outside_fault_flag,
   input wire logic        trip_clear_flag,
   input wire logic        terminal_one_function,
   input wire logic        terminal_seven_function,
   input wire logic [31:0] output_frequency_setting,
   input wire logic [15:0] coil_command_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       first_q;
   logic [7:0] addr_q;
   // remembers the address byte of the frame in progress
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         first_q <= 1'b1;
         addr_q  <= 8'h00;
      end else if (rx_end) begin
         first_q <= 1'b1;
      end else if (rx_valid) begin
         first_q <= 1'b0;
         if (first_q) begin
            addr_q <= rx_byte;
         end
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // a good frame for this slave, and a reply line that stays idle
   sequence s_mine;
      rx_end && rx_crc_ok && !first_q && addr_q == own_address && !tx_valid;
   endsequence
   sequence s_quiet;
      !tx_valid [*6];
   endsequence
   a_reply_latency: assert property (s_mine |-> ##3 !tx_valid ##1 tx_valid)
      else $error("reply did not start four cycles after frame end");
   a_broadcast_quiet: assert property (rx_end && addr_q == BROADCAST_ADDR |-> s_quiet)
      else $error("reply sent to a broadcast frame");
   a_foreign_quiet: assert property (rx_end && (!rx_crc_ok || (addr_q != own_address
      && addr_q != BROADCAST_ADDR)) |-> s_quiet)
      else $error("reply sent to a foreign or damaged frame");
   a_hold_offer: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("reply byte changed before it was taken");
   a_run_gate: assert property (run_command ==
      $past(coil_command_word[BIT_RUN] && run_source_select == RUN_SRC_MODBUS))
      else $error("run command not gated by run source");
   a_flag_map: assert property ({trip_clear_flag, outside_fault_flag,
      reverse_direction} == coil_command_word[4:2])
      else $error("flag outputs differ from command word");
   a_terminal_map: assert property (terminal_one_function == coil_command_word[7]
      && terminal_seven_function == coil_command_word[13])
      else $error("terminal outputs differ from command word");
   a_word_bit0: assert property (!coil_command_word[0])
      else $error("command word bit zero set");
   a_set_timing: assert property ($changed(output_frequency_setting)
      || $changed(coil_command_word) |-> $past(rx_end, 3))
      else $error("setting changed without a frame");
endmodule : mbw_core_chk

bind mbw_core mbw_core_chk mbw_core_chk_inst (.*);

// ---- mbw_master_model.sv ----
module mbw_master_model (
   // clock
   input wire logic        sys_clk,
   // request stream to the slave
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            rx_end,
   output logic            rx_crc_ok,
   // reply stream from the slave
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   output logic            tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow = 1'b0;  // stall the reply every other cycle
   // idle levels at time zero
   initial begin
      rx_valid  = 1'b0;
      rx_byte   = 8'h00;
      rx_end    = 1'b0;
      rx_crc_ok = 1'b0;
      tx_ready  = 1'b1;
   end
   // one request of six bytes, high byte first, then collect the reply
   task automatic xfer(input logic [47:0] req, input logic ok,
                       output logic [47:0] rsp, output int n);
      int t;
      rsp = '0;
      n   = 0;
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         #1;
         rx_valid = 1'b1;
         rx_byte  = req[47 - 8 * i -: 8];
      end
      @(posedge sys_clk);
      #1;
      rx_valid  = 1'b0;
      rx_byte   = ~rx_byte;  // released line shows no stale byte
      rx_end    = 1'b1;
      rx_crc_ok = ok;
      @(posedge sys_clk);
      #1;
      rx_end    = 1'b0;
      rx_crc_ok = 1'b0;
      t = 0;
      while (t < 40) begin
         @(posedge sys_clk);
         t++;
         if (tx_valid && tx_ready) begin
            rsp = {rsp[39:0], tx_data};
            n++;
            if (tx_last) begin
               break;
            end
         end
         #1;
         tx_ready = slow ? ~tx_ready : 1'b1;
      end
      #1;
      tx_ready = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : xfer
endmodule : mbw_master_model

// ---- tb_modbus_write_loopback_slave.sv ----
module tb_modbus_write_loopback_slave;
   timeunit 1ns;
   timeprecision 1ps;
   import mbw_pkg::*;
   logic        sys_clk, rst_b, rx_valid, rx_end, rx_crc_ok, tx_valid, tx_last, tx_ready;
   logic [7:0]  own_address, run_source_select, rx_byte, tx_data;
   logic        run_command, reverse_direction, outside_fault_flag, trip_clear_flag;
   logic        terminal_one_function, terminal_two_function, terminal_three_function;
   logic        terminal_four_function, terminal_five_function, terminal_six_function;
   logic        terminal_seven_function;
   logic [31:0] output_frequency_setting;
   logic [15:0] coil_command_word;
   logic [6:0]  terms;
   logic [2:0]  flags;
   logic [47:0] rsp;
   int          n, n_fail = 0, comparisons = 0;
   assign terms = {terminal_seven_function, terminal_six_function, terminal_five_function,
      terminal_four_function, terminal_three_function, terminal_two_function,
      terminal_one_function};
   assign flags = {trip_clear_flag, outside_fault_flag, reverse_direction};
   mbw_core mbw_core_inst (.*);
   mbw_master_model mbw_master_model_inst (.*);
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one request and its reply, a missing reply ends the run
   task automatic run(input logic [47:0] req, input logic [47:0] exp, input int exp_n,
                      input logic ok, input string what);
      mbw_master_model_inst.xfer(req, ok, rsp, n);
      check({what, " count"}, 48'(exp_n), 48'(n));
      check(what, exp, rsp);
      if (exp_n > 0 && n == 0) begin
         conclude();
      end
   endtask : run
   task automatic t_reset();
      check("word", 48'h0, 48'(coil_command_word));
      check("freq", 48'h0, 48'(output_frequency_setting));
   endtask : t_reset
   task automatic t_coil();
      run_source_select = RUN_SRC_MODBUS;
      run(48'h01_05_0000_ff00, 48'h01_05_0000_ff00, 6, 1'b1, "coil on");
      check("word", 48'h0002, 48'(coil_command_word));
      check("run", 48'h1, 48'(run_command));
      run_source_select = 8'h00;
      repeat (2) @(posedge sys_clk);
      #1;
      check("run", 48'h0, 48'(run_command));
      run(48'h01_05_0002_ff00, 48'h01_05_0002_ff00, 6, 1'b1, "coil 3");
      check("ext", 48'h1, 48'(outside_fault_flag));
      run(48'h01_05_000e_ff00, 48'h01_05_000e_ff00, 6, 1'b1, "coil f");
      run(48'h01_05_0000_0000, 48'h01_05_0000_0000, 6, 1'b1, "coil off");
      check("word", 48'h8008, 48'(coil_command_word));
      run(48'h01_05_0001_1234, 48'h018503, 3, 1'b1, "coil data");
      run(48'h01_05_000f_ff00, 48'h018502, 3, 1'b1, "coil 10");
   endtask : t_coil
   task automatic t_word();
      run_source_select = RUN_SRC_MODBUS;
      run(48'h01_06_1f00_2a97, 48'h01_06_1f00_2a97, 6, 1'b1, "word");
      check("word", 48'h2a96, 48'(coil_command_word));
      check("terms", 48'h55, 48'(terms));
      check("flags", 48'h5, 48'(flags));
      check("run", 48'h1, 48'(run_command));
   endtask : t_word
   task automatic t_freq();
      run(48'h01_06_0001_1388, 48'h01_06_0001_1388, 6, 1'b1, "freq");
      check("freq", 48'h1388, 48'(output_frequency_setting));
      run(48'h01_06_0000_0000, 48'h01_06_0000_0000, 6, 1'b1, "upper");
      check("freq", 48'h1388, 48'(output_frequency_setting));
      run(48'h01_06_0002_0001, 48'h018602, 3, 1'b1, "reg 3");
      // the upper word is only written with zero here; a single write reaches it like the lower word
   endtask : t_freq
   task automatic t_loop();
      mbw_master_model_inst.slow = 1'b1;
      run(48'h01_08_0000_a5c3, 48'h01_08_0000_a5c3, 6, 1'b1, "loop");
      mbw_master_model_inst.slow = 1'b0;
      run(48'h01_08_0001_1234, 48'h018801, 3, 1'b1, "loop sub");
      run(48'h01_2b_0000_0000, 48'h01ab01, 3, 1'b1, "func");
      run(48'h01_03_0000_0011, 48'h018303, 3, 1'b1, "count");
      run(48'h01_10_1102_0000, 48'h019003, 3, 1'b1, "count zero");
      run(48'h01_10_1102_0002, 48'h019001, 3, 1'b1, "multi");
   endtask : t_loop
   task automatic t_silent();
      run(48'h00_06_0001_0064, 48'h0, 0, 1'b1, "broadcast");
      check("freq", 48'h0064, 48'(output_frequency_setting));
      run(48'h05_06_0001_0099, 48'h0, 0, 1'b1, "foreign");
      run(48'h01_06_0001_0077, 48'h0, 0, 1'b0, "bad crc");
      check("freq", 48'h0064, 48'(output_frequency_setting));
   endtask : t_silent
   // main sequence
   initial begin
      rst_b = 1'b0;
      own_address = 8'h01;
      run_source_select = 8'h00;
      repeat (12) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_coil();
      t_word();
      t_freq();
      t_loop();
      t_silent();
      conclude();
   end
endmodule : tb_modbus_write_loopback_slave
